// *** bench/tpq_probe_model.sv ***
// touch probe contact model: a switch that chatters on each change made with quiet low
`timescale 1ns/100ps
module tpq_probe_model (
	input wire logic clk, // bench clock
	input wire logic press, // wanted contact state
	input wire logic quiet, // high for a clean change
	output logic contact = 1'b0 // level at the pin
);
	logic last = 1'b0;
	logic [2:0] left = 3'h0;
	// chatter lasts a few cycles, far below any settling time used
	always @(posedge clk) begin
		if (press !== last) begin
			last <= press;
			left <= quiet ? 3'h0 : 3'h6;
		end else if (left != 3'h0) begin
			left <= left - 3'h1;
		end
		contact <= (left != 3'h0 && left[1]) ? ~last : last;
	end
endmodule

// *** bench/tpq_top_props.sv ***
// checker: apb handshake and event timing at the top ports
`timescale 1ns/100ps
module tpq_top_props
	import tpq_pkg::*;
(
	input wire logic CLK, // clock
	input wire logic RST, // reset
	input wire logic PSEL, // select
	input wire logic PENABLE, // enable
	input wire logic [7:0] PADDR, // address
	input wire logic [1:0] STEP_EN, // steps
	input wire logic [31:0] PRDATA, // read data
	input wire logic PREADY, // ready
	input wire logic PSLVERR, // error
	input wire logic [1:0] HIT, // hits
	input wire logic [1:0] DIR_OUT, // directions
	input wire logic IRQ // interrupt
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// start of an access phase
	sequence s_access;
		PSEL && $rose(PENABLE);
	endsequence
	a_ready_wait: assert property (s_access |=> PREADY ##1 !PREADY)
		else $error("ready not one wait state");
	a_ready_cause: assert property ($rose(PREADY) |-> $past(PSEL && PENABLE))
		else $error("ready without access");
	a_err_unmapped: assert property (PREADY && PADDR > 8'h18
		|-> PSLVERR && PRDATA == 32'h0000_0000) else $error("no error");
	a_err_mapped: assert property (PREADY && PADDR <= 8'h18
		&& PADDR[1:0] == 2'b00 |-> !PSLVERR) else $error("false error");
	a_hit_pulse: assert property (HIT != 2'b00 |=> (HIT & $past(HIT)) == 2'b00)
		else $error("hit longer than a cycle");
	a_dir_cause: assert property ($changed(DIR_OUT) |->
		$past(STEP_EN, 2) != 2'b00) else $error("direction without step");
	a_err_alone: assert property (PSLVERR |-> PREADY)
		else $error("error outside ready");
	// outputs are cleared by reset itself, so no disable here
	a_reset_quiet: assert property (disable iff (1'b0) RST |=> HIT == 2'b00
		&& !PREADY && !IRQ && DIR_OUT == 2'b00) else $error("reset dirty");
endmodule

// *** bench/tpq_top_test.sv ***
// bench: probe, step and apb stimulus against a hit count model
`timescale 1ns/100ps
module tpq_top_test
	import tpq_pkg::*;
;
	localparam int TD = 8; // short tick keeps the run brief
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic err, pready, pslverr, irq;
	logic [7:0] paddr = 8'h00;
	logic [7:0] lfsr = 8'h29;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic [1:0] press = 2'b00;
	logic [1:0] quiet = 2'b00;
	logic [1:0] step_en = 2'b00;
	logic [1:0] step_dir = 2'b00;
	logic [1:0] t1, contact, hit, dir_out;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	int hits[2] = '{0, 0};
	int exp_hits[2] = '{0, 0};
	logic [7:0] ra[5] = '{OFS_CTRL, OFS_TIME0, OFS_TIME1, OFS_DIRF, OFS_MASK};
	logic [31:0] rv[5] = '{CTRL_RST, TIME_RST, TIME_RST,
		{16'h0000, DIRF_RST}, {28'h000_0000, MASK_RST}};

	always #12.5 clk = ~clk;

	tpq_top #(.TICK_DIV(TD)) tpq_top_inst (.CLK(clk), .RST(rst),
		.PROBE_IN(contact), .STEP_EN(step_en), .STEP_DIR(step_dir),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .HIT(hit), .DIR_OUT(dir_out), .IRQ(irq));

	for (genvar i = 0; i < 2; i++) begin : g_probe
		tpq_probe_model tpq_probe_model_inst (.clk(clk), .press(press[i]),
			.quiet(quiet[i]), .contact(contact[i]));
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic conclude;
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		num_checks++;
		if (got !== want) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask

	// one apb transfer; request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			$display("unexpected at %0t: no ready from slave", $time);
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic step;
		@(posedge clk);
		step_en <= 2'b11;
		@(posedge clk);
		step_en <= 2'b00;
	endtask

	// cycle count, hit tally and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (hit[0] === 1'b1)
			hits[0]++;
		if (hit[1] === 1'b1)
			hits[1]++;
		if (cyc == 6000) begin
			failures++;
			$display("unexpected at %0t: run timed out", $time);
			conclude();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// reset values, then an unmapped place
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ra[i], 32'h0000_0000);
			chk(rd, rv[i]);
		end
		apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		chk({31'h0, err}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		// every edge mode on probe 0, a random one on probe 1
		apb(1'b1, OFS_TIME0, 32'h0000_0002);
		apb(1'b1, OFS_TIME1, 32'h0000_0002);
		for (int e = 0; e < 4; e++) begin
			lfsr = lfsr_next(lfsr);
			t1 = lfsr[1:0];
			apb(1'b1, OFS_CTRL, {28'h000_0000, t1, e[1:0]});
			press <= 2'b11;
			repeat (60) @(posedge clk);
			press <= 2'b00;
			repeat (60) @(posedge clk);
			exp_hits[0] += e[0] + e[1];
			exp_hits[1] += t1[0] + t1[1];
			chk(hits[0], exp_hits[0]);
			chk(hits[1], exp_hits[1]);
		end
		// zero settling, then a release inside a 5 ms spacing
		quiet <= 2'b11;
		apb(1'b1, OFS_TIME0, 32'h0005_0000);
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		// probe 1 is disabled here, so its press must stay silent
		press <= 2'b11;
		repeat (12) @(posedge clk);
		chk(hits[0], exp_hits[0] + 1);
		press <= 2'b00;
		repeat (2 * TD) @(posedge clk);
		chk(hits[0], exp_hits[0] + 1);
		repeat (6 * TD) @(posedge clk);
		exp_hits[0] += 2;
		chk(hits[0], exp_hits[0]);
		// masked events keep the line low, unmasked raise it
		chk({31'h0, irq}, 32'h0000_0000);
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(rd, {30'h0, exp_hits[1] != 0, 1'b1});
		apb(1'b1, OFS_TIME0, 32'h0000_0000);
		apb(1'b1, OFS_MASK, 32'h0000_0001);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		press <= 2'b01;
		repeat (12) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		press <= 2'b00;
		// direction turns only on the third step the new way
		apb(1'b1, OFS_DIRF, 32'h0000_0003);
		step_dir <= 2'b11;
		step();
		step();
		repeat (4) @(posedge clk);
		chk({30'h0, dir_out}, 32'h0000_0000);
		step();
		repeat (3) @(posedge clk);
		chk({30'h0, dir_out}, 32'h0000_0003);
		apb(1'b0, OFS_STAT, 32'h0000_0000);
		chk(rd, 32'h0000_000C);
		chk(hits[1], exp_hits[1]);
		// both levels released, both directions turned
		apb(1'b0, OFS_LEVEL, 32'h0000_0000);
		chk(rd, 32'h0000_000C);
		conclude();
	end
endmodule

bind tpq_top tpq_top_props tpq_top_props_inst (.CLK(CLK), .RST(RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .STEP_EN(STEP_EN),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .HIT(HIT),
	.DIR_OUT(DIR_OUT), .IRQ(IRQ));

// *** logic/tpq_channel.sv ***
// one probe channel: debounce, edge select, spacing, direction filter
`timescale 1ns/100ps
module tpq_channel
	import tpq_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // sync reset
	input wire logic tick, // millisecond tick
	input wire logic probe_sync, // synchronised contact level
	input wire logic step_en, // motion increment pulse
	input wire logic step_dir, // increment direction
	input wire tpq_cfg_t cfg, // configuration
	output tpq_evt_t evt // event outputs
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETTLE = 2'b01,
		ST_SPACE = 2'b10
	} tpq_st_t;

	tpq_st_t st_reg, st_next;
	logic level_reg, level_next;
	logic [16:0] cnt_reg, cnt_next; // spare bit so limit plus one fits
	logic hit_reg, hit_next;
	logic dir_reg, dir_next;
	logic [15:0] dcnt_reg, dcnt_next;
	logic dch_reg, dch_next;
	logic edge_ok;

	// interval over: zero means none, else one tick past the limit,
	// so the free-running tick can never cut the time short
	function automatic logic elapsed(input logic [16:0] cnt,
		input logic [15:0] lim);
		elapsed = (lim == 16'h0000) || (cnt > {1'b0, lim});
	endfunction

	// debounce, qualify and space hits
	always_comb begin
		st_next = st_reg;
		level_next = level_reg;
		cnt_next = cnt_reg;
		hit_next = 1'b0;
		edge_ok = 1'b0;
		case (st_reg)
			ST_IDLE: begin
				if (probe_sync != level_reg) begin
					cnt_next = 17'h0_0000;
					st_next = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (probe_sync == level_reg) begin
					st_next = ST_IDLE;
				end else if (elapsed(cnt_reg, cfg.debounce_ms)) begin
					level_next = probe_sync;
					case (cfg.edge_sel)
						EDGE_RISE: edge_ok = probe_sync;
						EDGE_FALL: edge_ok = ~probe_sync;
						EDGE_BOTH: edge_ok = 1'b1;
						default: edge_ok = 1'b0;
					endcase
					hit_next = edge_ok;
					cnt_next = 17'h0_0000;
					st_next = edge_ok ? ST_SPACE : ST_IDLE;
				end else if (tick) begin
					cnt_next = cnt_reg + 17'h0_0001;
				end
			end
			ST_SPACE: begin
				if (elapsed(cnt_reg, cfg.spacing_ms)) begin
					st_next = ST_IDLE;
				end else if (tick) begin
					cnt_next = cnt_reg + 17'h0_0001;
				end
			end
			default: st_next = ST_IDLE;
		endcase
	end

	// direction filter for tip compensation
	always_comb begin
		dir_next = dir_reg;
		dcnt_next = dcnt_reg;
		dch_next = 1'b0;
		if (step_en) begin
			if (step_dir == dir_reg) begin
				dcnt_next = 16'h0000;
			end else if (dcnt_reg + 16'h0001 >= cfg.dir_factor) begin
				dir_next = step_dir;
				dcnt_next = 16'h0000;
				dch_next = 1'b1;
			end else begin
				dcnt_next = dcnt_reg + 16'h0001;
			end
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= ST_IDLE;
			level_reg <= 1'b0;
			cnt_reg <= 17'h0_0000;
			hit_reg <= 1'b0;
			dir_reg <= 1'b0;
			dcnt_reg <= 16'h0000;
			dch_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			level_reg <= level_next;
			cnt_reg <= cnt_next;
			hit_reg <= hit_next;
			dir_reg <= dir_next;
			dcnt_reg <= dcnt_next;
			dch_reg <= dch_next;
		end
	end

	assign evt = '{hit: hit_reg, level: level_reg, dir: dir_reg,
		dir_change: dch_reg};
endmodule

// *** logic/tpq_pkg.sv ***
// package: constants and types for the touch probe edge qualifier
package tpq_pkg;
	// clock rate and millisecond tick
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TICK_W = 16;
	// apb register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TIME0 = 8'h04;
	localparam logic [7:0] OFS_TIME1 = 8'h08;
	localparam logic [7:0] OFS_DIRF = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_LEVEL = 8'h18;
	// field positions
	localparam int CTRL_TYPE0 = 0;
	localparam int CTRL_TYPE1 = 2;
	localparam int CTRL_DIR0 = 4;
	localparam int CTRL_DIR1 = 5;
	localparam int TIME_DEB = 0;
	localparam int TIME_SPC = 16;
	localparam int STAT_HIT0 = 0;
	localparam int STAT_HIT1 = 1;
	localparam int STAT_DCH0 = 2;
	localparam int STAT_DCH1 = 3;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] TIME_RST = 32'h0000_0032;
	localparam logic [15:0] DIRF_RST = 16'h0028;
	localparam logic [3:0] MASK_RST = 4'h0;
	// edge selection
	typedef enum logic [1:0] {
		EDGE_OFF = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} tpq_edge_t;
	// per-probe configuration
	typedef struct packed {
		tpq_edge_t edge_sel;
		logic [15:0] debounce_ms;
		logic [15:0] spacing_ms;
		logic [15:0] dir_factor;
	} tpq_cfg_t;
	// per-probe outputs
	typedef struct packed {
		logic hit;
		logic level;
		logic dir;
		logic dir_change;
	} tpq_evt_t;
endpackage

// *** logic/tpq_top.sv ***
// top: apb registers, tick divider, pin sync, two probe channels
`timescale 1ns/100ps
module tpq_top
	import tpq_pkg::*;
#(
	parameter int NUM_PROBES = 2,
	parameter int TICK_DIV = TICK_CYCLES
)(
	input wire logic CLK, // system clock
	input wire logic RST, // sync reset, high
	input wire logic [1:0] PROBE_IN, // probe contacts, async
	input wire logic [1:0] STEP_EN, // motion increment pulses
	input wire logic [1:0] STEP_DIR, // increment directions
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb enable
	input wire logic PWRITE, // apb direction
	input wire logic [7:0] PADDR, // apb address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error
	output logic [1:0] HIT, // qualified hit pulses
	output logic [1:0] DIR_OUT, // accepted directions
	output logic IRQ // interrupt level
);
	logic [2:0] sync0_reg, sync0_next, sync1_reg, sync1_next;
	logic [1:0] probe_sync;
	logic [15:0] div_reg, div_next;
	logic tick_reg, tick_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] time0_reg, time0_next, time1_reg, time1_next;
	logic [15:0] dirf_reg, dirf_next;
	logic [3:0] stat_reg, stat_next, mask_reg, mask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ready_reg, ready_next, err_reg, err_next;
	logic irq_reg, irq_next;
	logic [1:0] hit_reg, hit_next, dir_reg, dir_next;
	tpq_cfg_t cfg [2];
	tpq_evt_t evt [2];
	logic [3:0] events;
	logic acc, wr, rd;

	// true for a mapped register address
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == OFS_CTRL) || (a == OFS_TIME0) ||
			(a == OFS_TIME1) || (a == OFS_DIRF) || (a == OFS_STAT) ||
			(a == OFS_MASK) || (a == OFS_LEVEL);
	endfunction

	// three-stage pin sync; change counts when stages 2 and 3 agree
	always_comb begin
		sync0_next = {sync0_reg[1:0], PROBE_IN[0]};
		sync1_next = {sync1_reg[1:0], PROBE_IN[1]};
	end
	assign probe_sync[0] = (sync0_reg[2] == sync0_reg[1]) ?
		sync0_reg[2] : evt[0].level;
	assign probe_sync[1] = (sync1_reg[2] == sync1_reg[1]) ?
		sync1_reg[2] : evt[1].level;

	always_comb begin
		tick_next = 1'b0;
		div_next = div_reg + 16'h0001;
		if (div_reg == 16'(TICK_DIV - 1)) begin
			div_next = 16'h0000;
			tick_next = 1'b1;
		end
	end

	// each probe has its own edge type and timing; both share the direction factor
	always_comb begin
		cfg[0] = '{edge_sel: tpq_edge_t'(ctrl_reg[CTRL_TYPE0+:2]),
			debounce_ms: time0_reg[TIME_DEB+:16],
			spacing_ms: time0_reg[TIME_SPC+:16], dir_factor: dirf_reg};
		cfg[1] = '{edge_sel: (NUM_PROBES > 1) ?
			tpq_edge_t'(ctrl_reg[CTRL_TYPE1+:2]) : EDGE_OFF,
			debounce_ms: time1_reg[TIME_DEB+:16],
			spacing_ms: time1_reg[TIME_SPC+:16], dir_factor: dirf_reg};
	end

	// probe channels
	for (genvar i = 0; i < 2; i++) begin : g_ch
		tpq_channel u_ch (
			.clk(CLK),
			.rst(RST),
			.tick(tick_reg),
			.probe_sync(probe_sync[i]),
			.step_en(STEP_EN[i]),
			.step_dir(STEP_DIR[i]),
			.cfg(cfg[i]),
			.evt(evt[i])
		);
	end

	assign events = {evt[1].dir_change, evt[0].dir_change,
		evt[1].hit, evt[0].hit};
	assign acc = PSEL && PENABLE && !ready_reg;
	assign wr = acc && PWRITE && addr_ok(PADDR);
	assign rd = acc && !PWRITE && addr_ok(PADDR);

	// apb slave, one wait state; status cleared by read, set wins
	always_comb begin
		ctrl_next = ctrl_reg;
		time0_next = time0_reg;
		time1_next = time1_reg;
		dirf_next = dirf_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		rdata_next = rdata_reg;
		ready_next = acc;
		err_next = acc && !addr_ok(PADDR);
		if (wr) begin
			case (PADDR)
				OFS_CTRL: ctrl_next = {26'h0, PWDATA[5:0]};
				OFS_TIME0: time0_next = PWDATA;
				OFS_TIME1: time1_next = PWDATA;
				OFS_DIRF: dirf_next = PWDATA[15:0];
				OFS_MASK: mask_next = PWDATA[3:0];
				default: ;
			endcase
		end
		if (rd) begin
			case (PADDR)
				OFS_CTRL: rdata_next = ctrl_reg;
				OFS_TIME0: rdata_next = time0_reg;
				OFS_TIME1: rdata_next = time1_reg;
				OFS_DIRF: rdata_next = {16'h0000, dirf_reg};
				OFS_STAT: rdata_next = {28'h000_0000, stat_reg};
				OFS_MASK: rdata_next = {28'h000_0000, mask_reg};
				OFS_LEVEL: rdata_next = {28'h000_0000, evt[1].dir,
					evt[0].dir, evt[1].level, evt[0].level};
				default: rdata_next = 32'h0000_0000;
			endcase
			if (PADDR == OFS_STAT) begin
				stat_next = 4'h0;
			end
		end else if (acc) begin
			rdata_next = 32'h0000_0000;
		end
		stat_next = stat_next | events;
		irq_next = |(stat_next & mask_next);
		hit_next = events[1:0];
		dir_next = {evt[1].dir, evt[0].dir};
	end

	// registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			sync0_reg <= 3'h0;
			sync1_reg <= 3'h0;
			div_reg <= 16'h0000;
			tick_reg <= 1'b0;
			ctrl_reg <= CTRL_RST;
			time0_reg <= TIME_RST;
			time1_reg <= TIME_RST;
			dirf_reg <= DIRF_RST;
			mask_reg <= MASK_RST;
			stat_reg <= 4'h0;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
			err_reg <= 1'b0;
			irq_reg <= 1'b0;
			hit_reg <= 2'h0;
			dir_reg <= 2'h0;
		end else begin
			sync0_reg <= sync0_next;
			sync1_reg <= sync1_next;
			div_reg <= div_next;
			tick_reg <= tick_next;
			ctrl_reg <= ctrl_next;
			time0_reg <= time0_next;
			time1_reg <= time1_next;
			dirf_reg <= dirf_next;
			mask_reg <= mask_next;
			stat_reg <= stat_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg <= err_next;
			irq_reg <= irq_next;
			hit_reg <= hit_next;
			dir_reg <= dir_next;
		end
	end

	assign PRDATA = rdata_reg;
	assign PREADY = ready_reg;
	assign PSLVERR = err_reg;
	assign HIT = hit_reg;
	assign DIR_OUT = dir_reg;
	assign IRQ = irq_reg;
endmodule
